// file: iodr_pkg.sv
// ======================================================================
// shared constants and carriers for the imu output data registers
// ======================================================================
package iodr_pkg;

    // ==================================================================
    // register offsets, byte addresses on the plain register port
    // ==================================================================
    localparam logic [7:0] ACCEL_X_LOW_WORD_OFS = 8'h10;
    localparam logic [7:0] ACCEL_X_HIGH_WORD_OFS = 8'h12;
    localparam logic [7:0] ACCEL_Y_LOW_WORD_OFS = 8'h14;
    localparam logic [7:0] ACCEL_Y_HIGH_WORD_OFS = 8'h16;
    localparam logic [7:0] ACCEL_Z_LOW_WORD_OFS = 8'h18;
    localparam logic [7:0] ACCEL_Z_HIGH_WORD_OFS = 8'h1a;
    localparam logic [7:0] INTERNAL_TEMPERATURE_OFS = 8'h1c;
    localparam logic [7:0] SYNC_RELATIVE_TIME_OFS = 8'h1e;
    localparam logic [7:0] UPDATE_COUNTER_OFS = 8'h22;
    localparam logic [7:0] DELTA_ANGLE_X_LOW_WORD_OFS = 8'h24;
    localparam logic [7:0] DELTA_ANGLE_X_HIGH_WORD_OFS = 8'h26;
    localparam logic [7:0] DELTA_ANGLE_Y_LOW_WORD_OFS = 8'h28;
    localparam logic [7:0] DELTA_ANGLE_Y_HIGH_WORD_OFS = 8'h2a;
    localparam logic [7:0] DELTA_ANGLE_Z_LOW_WORD_OFS = 8'h2c;
    localparam logic [7:0] DELTA_ANGLE_Z_HIGH_WORD_OFS = 8'h2e;
    localparam logic [7:0] MISCELLANEOUS_CONTROL_OFS = 8'h60;
    localparam logic [7:0] DECIMATION_SETTING_OFS = 8'h64;
    localparam logic [7:0] RESET_COMMAND_OFS = 8'h68;
    localparam logic [7:0] RANGE_VARIANT_OFS = 8'h70;

    // ==================================================================
    // fields and reset values
    // ==================================================================
    localparam int SYNC_MODE_LSB = 2;
    localparam int SYNC_MODE_MSB = 4;
    localparam logic [2:0] SYNC_MODE_SCALED = 3'h2;
    localparam logic [15:0] MISC_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] DECIMATION_RESET = 16'h0000;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] TIME_STAMP_MAX = 16'hffff;
    localparam int RESET_COMMAND_BIT = 0;

    // ==================================================================
    // timing: one time stamp count and the clock it is counted on
    // ==================================================================
    localparam int CLK_PERIOD_PS = 100000;
    localparam int TIME_STAMP_LSB_PS = 49020000;
    localparam int TS_TICK_CYCLES = TIME_STAMP_LSB_PS / CLK_PERIOD_PS;
    localparam logic [9:0] TS_TICK_LAST = 10'(TS_TICK_CYCLES - 1);
    localparam int NOMINAL_SAMPLE_RATE_SPS = 2000;

    // ==================================================================
    // delta angle range variants, full scale in degrees
    // ==================================================================
    localparam logic [1:0] RANGE_LOW = 2'h0;
    localparam logic [1:0] RANGE_MID = 2'h1;
    localparam logic [1:0] RANGE_HIGH = 2'h2;
    localparam logic [15:0] FULL_SCALE_LOW_DEG = 16'h0168;
    localparam logic [15:0] FULL_SCALE_MID_DEG = 16'h02d0;
    localparam logic [15:0] FULL_SCALE_HIGH_DEG = 16'h0870;

    // ==================================================================
    // carriers
    // ==================================================================
    typedef struct packed {
        logic [2:0][31:0] gyro_rate;  // per axis, x in [0]
        logic [2:0][31:0] accel;      // high word in [31:16]
        logic [15:0] temp;
    } iodr_sample_type;

    typedef struct packed {
        logic [2:0][31:0] delta_angle;
        logic [2:0][31:0] accel;
        logic [15:0] temp;
    } iodr_update_type;

endpackage

// file: iodr_front.sv
`timescale 1ns/1ns
// ======================================================================
// sample side: decimation window and trapezoidal delta angle sums
// ======================================================================
module iodr_front (
    input wire logic link_clk,                          // sample clock
    input wire logic link_rst,                          // sync reset, link domain
    input wire logic sample_valid,                      // one sample this edge
    input wire iodr_pkg::iodr_sample_type sample,       // sample words
    input wire logic [15:0] cfg_decimation,             // held stable by main
    input wire logic cfg_toggle,                        // flips on new setting
    output iodr_pkg::iodr_update_type update,           // held until next update
    output logic update_toggle                          // flips per update
);
    logic cfg_meta;
    logic cfg_sync;
    logic cfg_seen;
    logic [15:0] decimation;
    logic [15:0] window_count;
    logic window_end;
    logic [2:0][31:0] delta_q;
    logic [2:0][31:0] accel_q;
    logic [15:0] temp_q;

    // setting crosses by toggle; the word changes with it and is stable before the synced flip
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            cfg_meta <= 1'b0;
            cfg_sync <= 1'b0;
            cfg_seen <= 1'b0;
            decimation <= iodr_pkg::DECIMATION_RESET;
        end else begin
            cfg_meta <= cfg_toggle;
            cfg_sync <= cfg_meta;
            cfg_seen <= cfg_sync;
            if (cfg_sync != cfg_seen) begin
                decimation <= cfg_decimation;
            end
        end
    end

    // window holds decimation plus one samples
    assign window_end = (window_count >= decimation);

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            window_count <= 16'h0000;
        end else if (sample_valid) begin
            window_count <= window_end ? 16'h0000 : window_count + 16'h0001;
        end
    end

    // per axis: sum of current plus previous rate; rate input is scaled
    // so the sum equals angle in full scale / 2^31 units at fs 2000
    for (genvar i = 0; i < 3; i++) begin : g_axis
        logic [31:0] prev_rate;
        logic [31:0] sum;
        logic [31:0] term;
        assign term = sample.gyro_rate[i] + prev_rate;
        always_ff @(posedge link_clk) begin
            if (link_rst) begin
                prev_rate <= 32'h0000_0000;
                sum <= 32'h0000_0000;
                delta_q[i] <= 32'h0000_0000;
            end else if (sample_valid) begin
                prev_rate <= sample.gyro_rate[i];
                if (window_end) begin
                    delta_q[i] <= sum + term;
                    sum <= 32'h0000_0000;
                end else begin
                    sum <= sum + term;
                end
            end
        end
    end

    // last sample of the window becomes the update; words move together
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            accel_q <= '0;
            temp_q <= 16'h0000;
            update_toggle <= 1'b0;
        end else if (sample_valid && window_end) begin
            accel_q <= sample.accel;
            temp_q <= sample.temp;
            update_toggle <= ~update_toggle;
        end
    end

    // one driver for the whole bundle; members follow the struct order
    assign update = {delta_q, accel_q, temp_q};

endmodule // iodr_front

// file: iodr_top.sv
`timescale 1ns/1ns
//
// Contract
// - accel high word is two's complement, 0.25 mg per count, zero reads 0.
// - each accel axis has a low word extending the high word to 32 bits.
// - accel x high 0x12, y low/high 0x14/0x16, z low/high 0x18/0x1a.
// - temperature word two's complement, 0.1 degC per count, zero reads 0.
// - time stamp counts 49.02 us units since last sync pulse, offset binary; the timer counts up from zero as plain unsigned.
// - time stamp only meaningful in scaled sync mode, code 010 in [4:2].
// - each update loads time from latest sync edge to its last sample.
// - update counter clears to zero at power-on and after reset command.
// - counter increments per update and wraps from 0xffff to zero.
// - counter reads as unsigned binary across all 16 bits.
// - delta angle sums current plus previous rate, scaled by 1/(2 fs).
// - each delta angle window holds decimation setting plus one samples.
// - internal sample clock nominally runs at 2000 samples per second.
// - two words per delta angle axis form one 32-bit result.
// - delta angle full scale is 360, 720 or 2160 degrees per variant.
// - delta angle high word counts full scale over 2^15, zero reads 0.
// - delta angle x low word at 0x24, high word at 0x26.
//
module iodr_top #(
    parameter logic [1:0] RANGE_VARIANT = iodr_pkg::RANGE_LOW  // build variant
) (
    input wire logic clk,                               // register clock, 10 MHz
    input wire logic rst,                               // sync reset, active high
    input wire logic link_clk,                          // sample clock
    input wire logic link_rst,                          // sync reset, link domain
    input wire logic sample_valid,                      // sample strobe, link domain
    input wire iodr_pkg::iodr_sample_type sample,       // sample words, link domain
    input wire logic sync_pin,                          // external sync, async
    input wire logic reset_cmd,                         // reset command pulse
    input wire logic [7:0] reg_addr,                    // register byte address
    input wire logic [15:0] reg_wdata,                  // write data
    input wire logic reg_wr,                            // write strobe
    input wire logic reg_rd,                            // read strobe
    output logic [15:0] reg_rdata,                      // read data, next cycle
    output logic data_ready_pin                         // pulse per update
);
    // ==================================================================
    // declarations
    // ==================================================================
    typedef enum logic [1:0] {
        IODR_IDLE = 2'b01,
        IODR_LOAD = 2'b10
    } iodr_state_type;

    iodr_state_type state;
    iodr_state_type next_state;
    iodr_pkg::iodr_update_type update_link;
    iodr_pkg::iodr_update_type shadow;
    logic update_toggle;
    logic upd_meta;
    logic upd_sync;
    logic upd_seen;
    logic update_event;
    logic sync_meta;
    logic sync_level;
    logic sync_prev;
    logic sync_edge;
    logic [9:0] tick_count;
    logic [15:0] ts_count;
    logic [15:0] misc_control;
    logic [15:0] decimation_setting;
    logic cfg_toggle;
    logic soft_reset;
    logic counter_clear;
    logic [15:0] update_counter;
    logic [15:0] sync_relative_time;
    logic [15:0] next_rdata;
    logic [2:0] sync_mode;
    logic [15:0] full_scale_deg;

    // ==================================================================
    // sample side
    // ==================================================================
    // integration runs on the sample clock; only whole updates cross
    iodr_front u_front (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .sample_valid(sample_valid),
        .sample(sample),
        .cfg_decimation(decimation_setting),
        .cfg_toggle(cfg_toggle),
        .update(update_link),
        .update_toggle(update_toggle)
    );

    // ==================================================================
    // update crossing
    // ==================================================================
    // toggle from the link side through two flops; the bundle is held
    // for a whole sample period, far longer than the crossing takes
    always_ff @(posedge clk) begin
        if (rst) begin
            upd_meta <= 1'b0;
            upd_sync <= 1'b0;
            upd_seen <= 1'b0;
        end else begin
            upd_meta <= update_toggle;
            upd_sync <= upd_meta;
            upd_seen <= upd_sync;
        end
    end

    assign update_event = (upd_sync != upd_seen);

    // ==================================================================
    // external sync and time stamp timer
    // ==================================================================
    // sync pin is asynchronous: two flops before the edge detector
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_meta <= 1'b0;
            sync_level <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_meta <= sync_pin;
            sync_level <= sync_meta;
            sync_prev <= sync_level;
        end
    end

    // rising edge restarts the elapsed time
    assign sync_edge = sync_level && !sync_prev;

    // one count per 49.02 us; the sub-cycle fraction is dropped, a small
    // rate error traded for a plain divider
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_count <= 10'h000;
            ts_count <= 16'h0000;
        end else if (sync_edge) begin
            tick_count <= 10'h000;
            ts_count <= 16'h0000;
        end else if (tick_count == iodr_pkg::TS_TICK_LAST) begin
            tick_count <= 10'h000;
            if (ts_count != iodr_pkg::TIME_STAMP_MAX) begin
                ts_count <= ts_count + 16'h0001;
            end
        end else begin
            tick_count <= tick_count + 10'h001;
        end
    end

    // ==================================================================
    // load sequencer
    // ==================================================================
    // idle until an update arrives, then one load cycle for all words
    always_comb begin
        case (state)
            IODR_IDLE: next_state = update_event ? IODR_LOAD : IODR_IDLE;
            IODR_LOAD: next_state = update_event ? IODR_LOAD : IODR_IDLE;
            default: next_state = IODR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IODR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==================================================================
    // output word shadow
    // ==================================================================
    // all high and low words are taken in the same cycle, so a high word and
    // its low word read between two updates never mix two sample sets
    always_ff @(posedge clk) begin
        if (rst) begin
            shadow <= '0;
        end else if (update_event) begin
            shadow <= update_link;
        end
    end

    // time stamp taken with the same update, counted to its last sample
    assign sync_mode = misc_control[iodr_pkg::SYNC_MODE_MSB:iodr_pkg::SYNC_MODE_LSB];

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_relative_time <= 16'h0000;
        end else if (update_event) begin
            // other sync modes report zero rather than a stale count
            if (sync_mode == iodr_pkg::SYNC_MODE_SCALED) begin
                sync_relative_time <= ts_count;
            end else begin
                sync_relative_time <= 16'h0000;
            end
        end
    end

    // ==================================================================
    // data update counter
    // ==================================================================
    // clear from reset, the reset command pin or the command register
    assign counter_clear = reset_cmd || soft_reset;

    always_ff @(posedge clk) begin
        if (rst) begin
            update_counter <= iodr_pkg::COUNTER_RESET;
        end else if (counter_clear) begin
            update_counter <= iodr_pkg::COUNTER_RESET;
        end else if (update_event) begin
            update_counter <= update_counter + 16'h0001;
        end
    end

    // data ready follows the load so the host always reads fresh words
    always_ff @(posedge clk) begin
        if (rst) begin
            data_ready_pin <= 1'b0;
        end else begin
            data_ready_pin <= (state == IODR_LOAD);
        end
    end

    // ==================================================================
    // control registers
    // ==================================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            misc_control <= iodr_pkg::MISC_CONTROL_RESET;
        end else if (reg_wr && reg_addr == iodr_pkg::MISCELLANEOUS_CONTROL_OFS) begin
            misc_control <= reg_wdata;
        end
    end

    // decimation setting crosses to the sample side by toggle; a second
    // write within a few link cycles may be missed, software writes rarely
    always_ff @(posedge clk) begin
        if (rst) begin
            decimation_setting <= iodr_pkg::DECIMATION_RESET;
            cfg_toggle <= 1'b0;
        end else if (reg_wr && reg_addr == iodr_pkg::DECIMATION_SETTING_OFS) begin
            decimation_setting <= reg_wdata;
            cfg_toggle <= ~cfg_toggle;
        end
    end

    // reset command register: write a one, one-cycle clear pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= reg_wr && (reg_addr == iodr_pkg::RESET_COMMAND_OFS)
                && reg_wdata[iodr_pkg::RESET_COMMAND_BIT];
        end
    end

    // ==================================================================
    // range variant
    // ==================================================================
    // delta angle words count full scale / 2^15 in the high word; the
    // sample side delivers rates already scaled for this variant
    always_comb begin
        case (RANGE_VARIANT)
            iodr_pkg::RANGE_LOW: full_scale_deg = iodr_pkg::FULL_SCALE_LOW_DEG;
            iodr_pkg::RANGE_MID: full_scale_deg = iodr_pkg::FULL_SCALE_MID_DEG;
            iodr_pkg::RANGE_HIGH: full_scale_deg = iodr_pkg::FULL_SCALE_HIGH_DEG;
            default: full_scale_deg = iodr_pkg::FULL_SCALE_LOW_DEG;
        endcase
    end

    // ==================================================================
    // read decode
    // ==================================================================
    // data words pass through untouched: scaling is fixed at the source
    always_comb begin
        case (reg_addr)
            iodr_pkg::ACCEL_X_LOW_WORD_OFS: next_rdata = shadow.accel[0][15:0];
            iodr_pkg::ACCEL_X_HIGH_WORD_OFS: next_rdata = shadow.accel[0][31:16];
            iodr_pkg::ACCEL_Y_LOW_WORD_OFS: next_rdata = shadow.accel[1][15:0];
            iodr_pkg::ACCEL_Y_HIGH_WORD_OFS: next_rdata = shadow.accel[1][31:16];
            iodr_pkg::ACCEL_Z_LOW_WORD_OFS: next_rdata = shadow.accel[2][15:0];
            iodr_pkg::ACCEL_Z_HIGH_WORD_OFS: next_rdata = shadow.accel[2][31:16];
            iodr_pkg::INTERNAL_TEMPERATURE_OFS: next_rdata = shadow.temp;
            iodr_pkg::SYNC_RELATIVE_TIME_OFS: next_rdata = sync_relative_time;
            iodr_pkg::UPDATE_COUNTER_OFS: next_rdata = update_counter;
            iodr_pkg::DELTA_ANGLE_X_LOW_WORD_OFS: next_rdata = shadow.delta_angle[0][15:0];
            iodr_pkg::DELTA_ANGLE_X_HIGH_WORD_OFS: next_rdata = shadow.delta_angle[0][31:16];
            iodr_pkg::DELTA_ANGLE_Y_LOW_WORD_OFS: next_rdata = shadow.delta_angle[1][15:0];
            iodr_pkg::DELTA_ANGLE_Y_HIGH_WORD_OFS: next_rdata = shadow.delta_angle[1][31:16];
            iodr_pkg::DELTA_ANGLE_Z_LOW_WORD_OFS: next_rdata = shadow.delta_angle[2][15:0];
            iodr_pkg::DELTA_ANGLE_Z_HIGH_WORD_OFS: next_rdata = shadow.delta_angle[2][31:16];
            iodr_pkg::MISCELLANEOUS_CONTROL_OFS: next_rdata = misc_control;
            iodr_pkg::DECIMATION_SETTING_OFS: next_rdata = decimation_setting;
            iodr_pkg::RANGE_VARIANT_OFS: next_rdata = full_scale_deg;
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // iodr_top

// file: iodr_chk_sva.sv
`timescale 1ns/1ns
// ======================================================================
// port checker for the output data registers
// ======================================================================
module iodr_chk #(
    parameter logic [1:0] RANGE_VARIANT = 2'h0 // build variant
) (
    input wire logic clk, // register clock
    input wire logic rst, // sync reset
    input wire logic reset_cmd, // counter clear pulse
    input wire logic [7:0] reg_addr, // byte address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic data_ready_pin // update pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] cnt;
    logic [2:0] mode;
    logic tz;
    wire clr = reset_cmd || (reg_wr && reg_addr == 8'h68 && reg_wdata[0]);
    wire [15:0] fs = RANGE_VARIANT == 2'h1 ? 16'd720 : RANGE_VARIANT == 2'h2 ? 16'd2160 : 16'd360;
    // counts update pulses, so counter reads are judged without the body
    always_ff @(posedge clk) begin
        if (rst || clr) cnt <= 16'h0000;
        else if (data_ready_pin) cnt <= cnt + 16'h0001;
    end
    // mirrors sync mode; the stamp is only meaningful if the last load ran scaled
    always_ff @(posedge clk) begin
        if (rst) mode <= 3'h0;
        else if (reg_wr && reg_addr == 8'h60) mode <= reg_wdata[4:2];
        if (rst) tz <= 1'b1;
        else if (data_ready_pin) tz <= mode != 3'h2;
    end
    rdata_stands_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    ready_pulse_a: assert property (data_ready_pin |=> !data_ready_pin)
        else $error("data ready longer than one cycle");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> reg_rdata == 16'h0000 && !data_ready_pin)
        else $error("outputs busy in reset");
    range_value_a: assert property (reg_rd && reg_addr == 8'h70 |=> reg_rdata == fs)
        else $error("range word wrong");
    counter_track_a: assert property ((reg_rd && reg_addr == 8'h22 && !data_ready_pin && !clr
        && !$past(clr) && !$past(clr, 2)) ##1 !data_ready_pin
        |-> reg_rdata == $past(cnt))
        else $error("counter not one per update");
    counter_clear_a: assert property (reset_cmd ##2 (reg_rd && reg_addr == 8'h22 && !data_ready_pin)
        |=> reg_rdata == 16'h0000)
        else $error("counter not cleared");
    stamp_idle_a: assert property (reg_rd && reg_addr == 8'h1e && tz && !data_ready_pin
        |=> reg_rdata == 16'h0000)
        else $error("stamp set outside scaled sync");
endmodule // iodr_chk
bind iodr_top iodr_chk #(.RANGE_VARIANT(RANGE_VARIANT)) iodr_chk_inst (.clk, .rst, .reset_cmd,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .data_ready_pin);

// file: iodr_sample_src.sv
`timescale 1ns/1ns
// ======================================================================
// sample source on the link clock, one sample per request toggle
// ======================================================================
module iodr_sample_src (
    input wire logic link_clk, // link clock
    input wire logic req, // toggles once per sample
    input wire iodr_pkg::iodr_sample_type smp, // words to send
    output logic sample_valid, // one link cycle
    output iodr_pkg::iodr_sample_type sample // scrambled when idle
);
    logic [2:0] sq = 3'h0;
    // two flops catch the toggle; idle words invert so stale data never pass
    always_ff @(posedge link_clk) begin
        sq <= {sq[1:0], req};
        sample_valid <= sq[2] ^ sq[1];
        sample <= (sq[2] ^ sq[1]) ? smp : ~sample;
    end
endmodule // iodr_sample_src

// file: tb_iodr_top.sv
`timescale 1ns/1ns
// ======================================================================
// bench: register reads after sample windows
// ======================================================================
module tb_iodr_top;
    logic clk = 0, link_clk = 0, rst = 1, link_rst = 1, sync_pin = 0, reset_cmd = 0;
    logic reg_wr = 0, reg_rd = 0, req = 0, sample_valid, data_ready_pin;
    logic [7:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata;
    iodr_pkg::iodr_sample_type smp = '0, sample, s1, s2;
    logic [2:0][31:0] dsum = '0, prev = '0;
    int err_total = 0, check_count = 0;
    iodr_top #(.RANGE_VARIANT(2'h1)) iodr_top_inst (.clk, .rst, .link_clk, .link_rst,
        .sample_valid, .sample, .sync_pin, .reset_cmd, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .data_ready_pin);
    iodr_sample_src iodr_sample_src_inst (.link_clk, .req, .smp, .sample_valid, .sample);
    // clocks; the link starts off phase
    always #50 clk = ~clk;
    initial #7 forever #15 link_clk = ~link_clk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) chk({16'h0, reg_rdata}, {16'h0, e});
    endtask
    // model sums current plus previous rate over the window
    task send(input iodr_pkg::iodr_sample_type s, input logic last);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 3; i++) begin
            dsum[i] = dsum[i] + s.gyro_rate[i] + prev[i];
            prev[i] = s.gyro_rate[i];
        end
        @(posedge clk) {smp, req} <= {s, ~req};
        repeat (40) @(posedge clk) if (data_ready_pin === 1'b1) seen = 1'b1;
        chk({31'h0, seen}, {31'h0, last});
    endtask
    task check_all(input iodr_pkg::iodr_sample_type s, input logic [15:0] n, input logic [15:0] t);
        for (int i = 0; i < 3; i++) begin
            rd(8'h10 + 8'(4 * i), s.accel[i][15:0]);
            rd(8'h12 + 8'(4 * i), s.accel[i][31:16]);
            rd(8'h24 + 8'(4 * i), dsum[i][15:0]);
            rd(8'h26 + 8'(4 * i), dsum[i][31:16]);
            dsum[i] = '0;
        end
        rd(8'h1c, s.temp);
        rd(8'h1e, t);
        rd(8'h22, n);
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        s1 = {96'h7fff0000_ffffff00_00010001, 96'h83000000_7d000000_ffffffff, 16'hfe70};
        s2 = {96'h10000000_00000100_80000000, 96'h00000001_00008000_00000000, 16'h00fa};
        repeat (16) @(posedge clk);
        {rst, link_rst} <= 2'b00;
        rd(8'h70, 16'd720);
        rd(8'h40, 16'h0000);
        rd(8'h22, 16'h0000);
        send(s1, 1'b1);
        check_all(s1, 16'd1, 16'h0);
        wr(8'h12, 16'h1234);
        send(s2, 1'b1);
        check_all(s2, 16'd2, 16'h0);
        wr(8'h64, 16'h0002);
        repeat (10) @(posedge clk);
        send(s1, 1'b0);
        send(s2, 1'b0);
        send(~s1, 1'b1);
        check_all(~s1, 16'd3, 16'h0);
        wr(8'h64, 16'h0000);
        wr(8'h60, 16'h0008);
        @(posedge clk) sync_pin <= 1'b1;
        repeat (4) @(posedge clk);
        sync_pin <= 1'b0;
        repeat (1700) @(posedge clk);
        send(s2, 1'b1);
        check_all(s2, 16'd4, 16'd3);
        @(posedge clk) reset_cmd <= 1'b1;
        @(posedge clk) reset_cmd <= 1'b0;
        rd(8'h22, 16'h0000);
        send(s1, 1'b1);
        rd(8'h22, 16'h0001);
        wr(8'h68, 16'h0001);
        rd(8'h22, 16'h0000);
        test_done;
    end
    // watchdog, about four and a half times the expected run
    initial begin
        #1000000;
        err_total++;
        test_done;
    end
endmodule // tb_iodr_top
